/* rtl/dsc_pkg.sv */
// Constants for the DMA status, counter and readback block
package dsc_pkg;
  localparam logic [7:0] CMD_RESET = 8'hC3;
  localparam logic [7:0] CMD_LOAD = 8'hCF;
  localparam logic [7:0] CMD_CONTINUE = 8'hD3;
  localparam logic [7:0] CMD_READ_STATUS = 8'hBF;
  localparam logic [7:0] CMD_READ_RESTART = 8'hA7;
  localparam logic [7:0] CMD_MASK_FOLLOWS = 8'hBB;
  localparam logic [7:0] CMD_STATUS_REINIT = 8'h8B;
  localparam int REG_COUNT = 7;
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_COUNT_LOW = 3'h1;
  localparam logic [2:0] REG_COUNT_HIGH = 3'h2;
  localparam logic [2:0] REG_A_LOW = 3'h3;
  localparam logic [2:0] REG_A_HIGH = 3'h4;
  localparam logic [2:0] REG_B_LOW = 3'h5;
  localparam logic [2:0] REG_B_HIGH = 3'h6;
  localparam logic [6:0] MASK_RESET = 7'h7F;
  localparam int ST_BUS_REQ = 0;
  localparam int ST_RDY_N = 1;
  localparam int ST_IP_N = 3;
  localparam int ST_MATCH_N = 4;
  localparam int ST_EOB_N = 5;
  localparam logic [1:0] MODE_DEC = 2'h0;
  localparam logic [1:0] MODE_INC = 2'h1;
  typedef enum logic [1:0]
  {
    CTL_IDLE = 2'h1,
    CTL_MASK = 2'h2
  } dsc_ctl_type;
endpackage

/* rtl/dsc_addr_ctr.sv */
// Port address counter with load, step and fixed-address hold
`timescale 1ns/1ps
module dsc_addr_ctr #(
  parameter int WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] start_in,
  input wire logic step_in,
  input wire logic [1:0] mode_in,
  output logic [WIDTH-1:0] addr_out
);
  // Load beats a step in the same cycle; fixed modes simply hold
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      addr_out <= '0;
    else if (load_in)
      addr_out <= start_in;
    else if (step_in && mode_in == dsc_pkg::MODE_INC)
      addr_out <= addr_out + WIDTH'(1);
    else if (step_in && mode_in == dsc_pkg::MODE_DEC)
      addr_out <= addr_out - WIDTH'(1);
  end
endmodule // dsc_addr_ctr

/* rtl/dsc_read_seq.sv */
// Read sequence pointer logic: lowest and next mask-enabled register
`timescale 1ns/1ps
module dsc_read_seq #(
  parameter int REGS = 7
) (
  input wire logic [REGS-1:0] mask_in,
  input wire logic [2:0] ptr_in,
  output logic [2:0] lowest_out,
  output logic [2:0] next_out
);
  logic above;

  // Scan downward so the lowest qualifying index wins
  always_comb
  begin
    lowest_out = ptr_in;
    next_out = ptr_in;
    above = 1'h0;
    for (int i = REGS - 1; i >= 0; i--)
    begin
      if (mask_in[i])
        lowest_out = 3'(i);
      if (mask_in[i] && 3'(i) > ptr_in)
      begin
        next_out = 3'(i);
        above = 1'h1;
      end
    end
    if (!above)
      next_out = lowest_out;
  end
endmodule // dsc_read_seq

/* rtl/dsc_top.sv */
// Status byte, byte counter, address counters and host readback sequence
`timescale 1ns/1ps
module dsc_top #(
  parameter int CNT_W = 16
) (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic CTRL_WR_IN,
  input wire logic [7:0] CTRL_DATA_IN,
  input wire logic RD_STB_IN,
  input wire logic BUS_REQ_IN,
  input wire logic RDY_ACTIVE_IN,
  input wire logic INT_PENDING_IN,
  input wire logic READ_DONE_IN,
  input wire logic WRITE_DONE_IN,
  input wire logic MATCH_IN,
  input wire logic A_IS_SOURCE_IN,
  input wire logic [CNT_W-1:0] BLOCK_LEN_IN,
  input wire logic [CNT_W-1:0] PORT_A_START_IN,
  input wire logic [CNT_W-1:0] PORT_B_START_IN,
  input wire logic [1:0] PORT_A_MODE_IN,
  input wire logic [1:0] PORT_B_MODE_IN,
  input wire logic PULSE_EN_IN,
  input wire logic [7:0] PULSE_CTRL_IN,
  output logic [7:0] RD_DATA_OUT,
  output logic RD_VALID_OUT,
  output logic STOPPED_OUT,
  output logic EOB_OUT,
  output logic PULSE_HIT_OUT
);
  dsc_pkg::dsc_ctl_type ctl_reg;
  dsc_pkg::dsc_ctl_type ctl_next;
  logic cmd_reset;
  logic cmd_load;
  logic cmd_cont;
  logic cmd_reinit;
  logic cmd_status;
  logic cmd_restart;
  logic cmd_mask;
  logic mask_wr;
  logic [6:0] mask_reg;
  logic [2:0] ptr_reg;
  logic [2:0] ptr_lowest;
  logic [2:0] ptr_after;
  logic status_sel_reg;
  logic bus_req_reg;
  logic rdy_n_reg;
  logic ip_n_reg;
  logic match_n_reg;
  logic eob_n_reg;
  logic [7:0] status_byte;
  logic [CNT_W-1:0] count_reg;
  logic count_clr;
  logic eob_hit;
  logic stop_now;
  logic a_step;
  logic b_step;
  logic src_step;
  logic dst_step;
  logic [CNT_W-1:0] a_addr;
  logic [CNT_W-1:0] b_addr;
  logic [7:0] sel_data;

  // Command decode; a byte after the mask announcement is data, not a command
  assign mask_wr = CTRL_WR_IN && ctl_reg == dsc_pkg::CTL_MASK;
  assign cmd_reset = CTRL_WR_IN && ctl_reg == dsc_pkg::CTL_IDLE
    && CTRL_DATA_IN == dsc_pkg::CMD_RESET;
  assign cmd_load = CTRL_WR_IN && ctl_reg == dsc_pkg::CTL_IDLE
    && CTRL_DATA_IN == dsc_pkg::CMD_LOAD;
  assign cmd_cont = CTRL_WR_IN && ctl_reg == dsc_pkg::CTL_IDLE
    && CTRL_DATA_IN == dsc_pkg::CMD_CONTINUE;
  assign cmd_reinit = CTRL_WR_IN && ctl_reg == dsc_pkg::CTL_IDLE
    && CTRL_DATA_IN == dsc_pkg::CMD_STATUS_REINIT;
  assign cmd_status = CTRL_WR_IN && ctl_reg == dsc_pkg::CTL_IDLE
    && CTRL_DATA_IN == dsc_pkg::CMD_READ_STATUS;
  assign cmd_restart = CTRL_WR_IN && ctl_reg == dsc_pkg::CTL_IDLE
    && CTRL_DATA_IN == dsc_pkg::CMD_READ_RESTART;
  assign cmd_mask = CTRL_WR_IN && ctl_reg == dsc_pkg::CTL_IDLE
    && CTRL_DATA_IN == dsc_pkg::CMD_MASK_FOLLOWS;

  // Control byte state: idle, or waiting for the read mask byte
  always_comb
  begin
    ctl_next = ctl_reg;
    case (ctl_reg)
      dsc_pkg::CTL_IDLE:
        if (cmd_mask)
          ctl_next = dsc_pkg::CTL_MASK;
      dsc_pkg::CTL_MASK:
        if (CTRL_WR_IN)
          ctl_next = dsc_pkg::CTL_IDLE;
      default:
        ctl_next = dsc_pkg::CTL_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      ctl_reg <= dsc_pkg::CTL_IDLE;
    else
      ctl_reg <= ctl_next;
  end

  // Read mask; all registers enabled out of reset so reads work unprogrammed
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      mask_reg <= dsc_pkg::MASK_RESET;
    else if (mask_wr)
      mask_reg <= CTRL_DATA_IN[6:0];
  end

  dsc_read_seq #(
    .REGS(dsc_pkg::REG_COUNT)
  ) u_seq (
    .mask_in(mask_reg),
    .ptr_in(ptr_reg),
    .lowest_out(ptr_lowest),
    .next_out(ptr_after)
  );

  // Read pointer; the reset command leaves it alone, restart and each sequence read move it
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      ptr_reg <= dsc_pkg::REG_STATUS;
    else if (cmd_restart)
      ptr_reg <= ptr_lowest;
    else if (RD_STB_IN && !status_sel_reg)
      ptr_reg <= ptr_after;
  end

  // One-shot status selection; it does not disturb the sequence pointer
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      status_sel_reg <= 1'h0;
    else if (cmd_status)
      status_sel_reg <= 1'h1;
    else if (RD_STB_IN)
      status_sel_reg <= 1'h0;
  end

  // Bus request seen since load; a request in the load cycle still counts
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      bus_req_reg <= 1'h0;
    else if (BUS_REQ_IN)
      bus_req_reg <= 1'h1;
    else if (cmd_load)
      bus_req_reg <= 1'h0;
  end

  // Live line levels, registered once for a clean read
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      rdy_n_reg <= 1'h1;
      ip_n_reg <= 1'h1;
    end
    else
    begin
      rdy_n_reg <= !RDY_ACTIVE_IN;
      ip_n_reg <= !INT_PENDING_IN;
    end
  end

  // Match flag, active low; a match beats a same-cycle reinitialize
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      match_n_reg <= 1'h1;
    else if (MATCH_IN)
      match_n_reg <= 1'h0;
    else if (cmd_reinit || cmd_reset)
      match_n_reg <= 1'h1;
  end

  // End-of-block flag, active low; the event beats a same-cycle reinitialize, while load, continue and reset suppress the event
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      eob_n_reg <= 1'h1;
    else if (eob_hit)
      eob_n_reg <= 1'h0;
    else if (cmd_reinit || cmd_reset || cmd_load || cmd_cont)
      eob_n_reg <= 1'h1;
  end

  // Status byte; meaningless bits are driven low
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[dsc_pkg::ST_BUS_REQ] = bus_req_reg;
    status_byte[dsc_pkg::ST_RDY_N] = rdy_n_reg;
    status_byte[dsc_pkg::ST_IP_N] = ip_n_reg;
    status_byte[dsc_pkg::ST_MATCH_N] = match_n_reg;
    status_byte[dsc_pkg::ST_EOB_N] = eob_n_reg;
  end

  // The stopping read is not counted; a later extra read still is
  assign count_clr = cmd_load || cmd_cont || cmd_reset;
  assign eob_hit = READ_DONE_IN && !STOPPED_OUT && !count_clr
    && count_reg == BLOCK_LEN_IN;
  assign stop_now = eob_hit
    || (READ_DONE_IN && MATCH_IN && !STOPPED_OUT);

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      count_reg <= '0;
    else if (count_clr)
      count_reg <= '0;
    else if (READ_DONE_IN && !stop_now)
      count_reg <= count_reg + CNT_W'(1);
  end

  // Stopped until a command rearms the operation
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      STOPPED_OUT <= 1'h0;
    else if (count_clr)
      STOPPED_OUT <= 1'h0;
    else if (stop_now || (MATCH_IN && !READ_DONE_IN))
      STOPPED_OUT <= 1'h1;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      EOB_OUT <= 1'h0;
    else
      EOB_OUT <= eob_hit;
  end

  // Pulse compare after each transfer, against the low counter byte
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
      PULSE_HIT_OUT <= 1'h0;
    else
      PULSE_HIT_OUT <= PULSE_EN_IN && WRITE_DONE_IN
        && count_reg[7:0] == PULSE_CTRL_IN;
  end

  // Source steps on every read; destination skips the write after a stop,
  // which leaves it one behind the source as the ending values require
  assign src_step = READ_DONE_IN;
  assign dst_step = WRITE_DONE_IN && !STOPPED_OUT;
  assign a_step = A_IS_SOURCE_IN ? src_step : dst_step;
  assign b_step = A_IS_SOURCE_IN ? dst_step : src_step;

  dsc_addr_ctr #(
    .WIDTH(CNT_W)
  ) u_port_a (
    .clk_in(CLK_SYS_IN),
    .rstn_in(RSTN_IN),
    .load_in(cmd_load),
    .start_in(PORT_A_START_IN),
    .step_in(a_step),
    .mode_in(PORT_A_MODE_IN),
    .addr_out(a_addr)
  );

  dsc_addr_ctr #(
    .WIDTH(CNT_W)
  ) u_port_b (
    .clk_in(CLK_SYS_IN),
    .rstn_in(RSTN_IN),
    .load_in(cmd_load),
    .start_in(PORT_B_START_IN),
    .step_in(b_step),
    .mode_in(PORT_B_MODE_IN),
    .addr_out(b_addr)
  );

  // Readback mux over the seven registers
  always_comb
  begin
    case (status_sel_reg ? dsc_pkg::REG_STATUS : ptr_reg)
      dsc_pkg::REG_STATUS: sel_data = status_byte;
      dsc_pkg::REG_COUNT_LOW: sel_data = count_reg[7:0];
      dsc_pkg::REG_COUNT_HIGH: sel_data = count_reg[15:8];
      dsc_pkg::REG_A_LOW: sel_data = a_addr[7:0];
      dsc_pkg::REG_A_HIGH: sel_data = a_addr[15:8];
      dsc_pkg::REG_B_LOW: sel_data = b_addr[7:0];
      dsc_pkg::REG_B_HIGH: sel_data = b_addr[15:8];
      default: sel_data = 8'h00;
    endcase
  end

  // An empty mask still answers, with zero, so the host never hangs
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      RD_DATA_OUT <= 8'h00;
      RD_VALID_OUT <= 1'h0;
    end
    else
    begin
      RD_VALID_OUT <= RD_STB_IN;
      if (RD_STB_IN)
        RD_DATA_OUT <= (mask_reg == 7'h00 && !status_sel_reg) ? 8'h00
          : sel_data;
    end
  end

  default clocking dsc_cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RSTN_IN);

  chk_load_clears_count: assert property (
    cmd_load |=> count_reg == '0)
    else $error("byte counter not cleared by load");

  chk_read_counts_up: assert property (
    READ_DONE_IN && !stop_now && !count_clr
      |=> count_reg == $past(count_reg) + CNT_W'(1))
    else $error("byte counter did not step on read");

  chk_eob_stop_flag: assert property (
    eob_hit |=> EOB_OUT && STOPPED_OUT && !eob_n_reg
      ##1 !EOB_OUT)
    else $error("end of block not signalled");

  chk_match_holds_low: assert property (
    MATCH_IN && !cmd_reinit ##1 !cmd_reinit && !cmd_reset
      |-> !match_n_reg ##1 !match_n_reg)
    else $error("match flag did not stay low");

  chk_reinit_sets_flags: assert property (
    cmd_reinit && !MATCH_IN && !eob_hit
      |=> match_n_reg && eob_n_reg && $stable(bus_req_reg))
    else $error("reinitialize touched the wrong bits");

  chk_rdy_bit_level: assert property (
    rdy_n_reg == !$past(RDY_ACTIVE_IN))
    else $error("request line status bit wrong");

  chk_bus_req_seen: assert property (
    BUS_REQ_IN |=> bus_req_reg ##1 (bus_req_reg || $past(cmd_load)))
    else $error("bus request bit lost");

  chk_restart_lowest: assert property (
    cmd_restart |=> ptr_reg == $past(ptr_lowest))
    else $error("restart did not pick lowest register");

  chk_status_readback: assert property (
    status_sel_reg && RD_STB_IN |=> RD_VALID_OUT
      && RD_DATA_OUT == $past(status_byte) && !status_sel_reg)
    else $error("status byte not returned");

  chk_fixed_port_hold: assert property (
    PORT_A_MODE_IN[1] && !cmd_load |=> $stable(a_addr))
    else $error("fixed port address moved");

  cov_end_of_block: cover property (eob_hit ##[1:4] READ_DONE_IN);
  cov_match_stop: cover property (READ_DONE_IN && MATCH_IN && !STOPPED_OUT);
  cov_mask_then_read: cover property (mask_wr ##[1:8] cmd_restart ##[1:8] RD_STB_IN);
endmodule // dsc_top

/* verification/dsc_host_model.sv */
// Host processor model: control byte writes and register reads
`timescale 1ns/1ps
module dsc_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output logic ctrl_wr_out,
  output logic [7:0] ctrl_data_out,
  output logic rd_stb_out
);
  // Quiet bus at time zero
  initial
  begin
    ctrl_wr_out = 1'h0;
    ctrl_data_out = 8'h00;
    rd_stb_out = 1'h0;
  end

  // One control byte; data line is scrambled after release so stale bytes never look valid
  task automatic wr(input logic [7:0] b);
    @(negedge clk_in);
    ctrl_wr_out = 1'h1;
    ctrl_data_out = b;
    @(negedge clk_in);
    ctrl_wr_out = 1'h0;
    ctrl_data_out = ~b;
  endtask

  // One read; the answer is registered on the edge that takes the strobe and sampled half a cycle later
  task automatic rd(output logic [7:0] b);
    @(negedge clk_in);
    rd_stb_out = 1'h1;
    @(negedge clk_in);
    rd_stb_out = 1'h0;
    b = (rd_valid_in === 1'h1) ? rd_data_in : 8'hXX;
  endtask
endmodule // dsc_host_model

/* verification/dsc_top_tb_top.sv */
// Self-checking testbench for the status, counter and readback block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module dsc_top_tb_top;
  logic clk, rstn, ctrl_wr, rd_stb, bus_req, rdy_act, int_pend, rd_done, wr_done, match;
  logic a_src, pulse_en, rd_valid, stopped, eob, pulse_hit;
  logic [7:0] ctrl_data, pulse_ctrl, rd_data, d;
  logic [15:0] blen, a_start, b_start;
  logic [1:0] a_mode, b_mode;
  int n_errors = 0;
  int total_checks = 0;
  int n_eob = 0;
  int n_hit = 0;

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Count single-cycle event pulses so none can slip by unseen
  always @(posedge clk)
  begin
    if (eob === 1'h1) n_eob++;
    if (pulse_hit === 1'h1) n_hit++;
  end

  dsc_top dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .CTRL_WR_IN(ctrl_wr), .CTRL_DATA_IN(ctrl_data),
    .RD_STB_IN(rd_stb), .BUS_REQ_IN(bus_req), .RDY_ACTIVE_IN(rdy_act),
    .INT_PENDING_IN(int_pend), .READ_DONE_IN(rd_done), .WRITE_DONE_IN(wr_done),
    .MATCH_IN(match), .A_IS_SOURCE_IN(a_src), .BLOCK_LEN_IN(blen),
    .PORT_A_START_IN(a_start), .PORT_B_START_IN(b_start), .PORT_A_MODE_IN(a_mode),
    .PORT_B_MODE_IN(b_mode), .PULSE_EN_IN(pulse_en), .PULSE_CTRL_IN(pulse_ctrl),
    .RD_DATA_OUT(rd_data), .RD_VALID_OUT(rd_valid), .STOPPED_OUT(stopped), .EOB_OUT(eob),
    .PULSE_HIT_OUT(pulse_hit));

  dsc_host_model host (.clk_in(clk), .rd_data_in(rd_data), .rd_valid_in(rd_valid),
    .ctrl_wr_out(ctrl_wr), .ctrl_data_out(ctrl_data), .rd_stb_out(rd_stb));

  // Expected status byte; undefined bits read as zero
  function automatic logic [7:0] stat(input logic bus, input logic m_n, input logic e_n);
    return {2'h0, e_n, m_n, ~int_pend, 1'h0, ~rdy_act, bus};
  endfunction

  // One engine beat: read done, write done and match for one cycle
  task automatic ev(input logic r, input logic w, input logic m);
    @(negedge clk);
    rd_done = r;
    wr_done = w;
    match = m;
    @(negedge clk);
    rd_done = 1'h0;
    wr_done = 1'h0;
    match = 1'h0;
  endtask

  // Restart the sequence and read all seven registers with the full mask
  task automatic check_regs(input logic [7:0] st, input logic [15:0] c, input logic [15:0] a,
    input logic [15:0] b);
    logic [7:0] exp_val [7];
    exp_val = '{st, c[7:0], c[15:8], a[7:0], a[15:8], b[7:0], b[15:8]};
    host.wr(8'hA7);
    for (int i = 0; i < 7; i++)
    begin
      host.rd(d);
      `CHK(d, exp_val[i])
    end
  endtask

  // Single place where the run ends
  task automatic end_of_test;
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Cuts a hang short; the sequence needs only a few microseconds
  initial
  begin
    #50000;
    n_errors++;
    end_of_test;
  end

  // Main sequence
  initial
  begin
    {rstn, bus_req, rdy_act, int_pend, rd_done, wr_done, match} = 7'h00;
    a_src = 1'h1;
    pulse_en = 1'h1;
    pulse_ctrl = 8'h02;
    blen = 16'h0003;
    a_start = 16'h1000;
    b_start = 16'h2000;
    a_mode = 2'h1;
    b_mode = 2'h1;
    repeat (2) @(posedge clk);
    @(negedge clk) rstn = 1'h1;
    check_regs(stat(1'h0, 1'h1, 1'h1), 16'h0000, 16'h0000, 16'h0000);
    // Inverted status inputs, read through the one-shot status command
    @(negedge clk);
    rdy_act = 1'h1;
    int_pend = 1'h1;
    host.wr(8'hBF);
    host.rd(d);
    `CHK(d, 8'h30)
    @(negedge clk);
    rdy_act = 1'h0;
    int_pend = 1'h0;
    // Transfer of block length 3: four reads, the last write after the stop is dropped
    host.wr(8'hCF);
    @(negedge clk) bus_req = 1'h1;
    @(negedge clk) bus_req = 1'h0;
    for (int k = 0; k < 3; k++)
    begin
      ev(1'h1, 1'h0, 1'h0);
      ev(1'h0, 1'h1, 1'h0);
    end
    ev(1'h1, 1'h0, 1'h0);
    `CHK(stopped, 1'h1)
    ev(1'h0, 1'h1, 1'h0);
    check_regs(stat(1'h1, 1'h1, 1'h0), 16'h0003, 16'h1004, 16'h2003);
    `CHK(n_eob, 1)
    `CHK(n_hit, 1)
    // Reduced mask: only the counter bytes, with a status peek in the middle
    host.wr(8'hBB);
    host.wr(8'h06);
    host.wr(8'hA7);
    host.rd(d);
    `CHK(d, 8'h03)
    host.wr(8'hBF);
    host.rd(d);
    `CHK(d, stat(1'h1, 1'h1, 1'h0))
    host.rd(d);
    `CHK(d, 8'h00)
    host.rd(d);
    `CHK(d, 8'h03)
    host.wr(8'hBB);
    host.wr(8'h7F);
    // Continue clears the count and end-of-block flag but keeps both addresses
    host.wr(8'hD3);
    check_regs(stat(1'h1, 1'h1, 1'h1), 16'h0000, 16'h1004, 16'h2003);
    // Search ending on a match at byte 3: B fixed source, A decrementing destination
    @(negedge clk);
    a_src = 1'h0;
    a_mode = 2'h0;
    b_mode = 2'h2;
    pulse_en = 1'h0;
    pulse_ctrl = 8'h01;
    // New block length and starts; only the new starts are proven sampled, the block length is never reached
    blen = 16'h0010;
    a_start = 16'h1100;
    b_start = 16'h2100;
    host.wr(8'hCF);
    for (int k = 0; k < 2; k++)
    begin
      ev(1'h1, 1'h0, 1'h0);
      ev(1'h0, 1'h1, 1'h0);
    end
    ev(1'h1, 1'h0, 1'h1);
    `CHK(stopped, 1'h1)
    check_regs(stat(1'h0, 1'h0, 1'h1), 16'h0002, 16'h10FE, 16'h2100);
    ev(1'h1, 1'h0, 1'h0);
    check_regs(stat(1'h0, 1'h0, 1'h1), 16'h0003, 16'h10FE, 16'h2100);
    host.wr(8'h8B);
    check_regs(stat(1'h0, 1'h1, 1'h1), 16'h0003, 16'h10FE, 16'h2100);
    host.wr(8'hC3);
    check_regs(stat(1'h0, 1'h1, 1'h1), 16'h0000, 16'h10FE, 16'h2100);
    // Destination A now fixed as well: a read and a write move neither address
    @(negedge clk);
    a_mode = 2'h2;
    ev(1'h1, 1'h0, 1'h0);
    ev(1'h0, 1'h1, 1'h0);
    check_regs(stat(1'h0, 1'h1, 1'h1), 16'h0001, 16'h10FE, 16'h2100);
    `CHK(n_eob, 1)
    `CHK(n_hit, 1)
    end_of_test;
  end
endmodule // dsc_top_tb_top
